// file: ceo_consts.svh
// constants for the configuration-write, memory-read and flag-set executor
`ifndef CEO_CONSTS_SVH
`define CEO_CONSTS_SVH
`define CEO_WORD_W 24
`define CEO_BYTE_W 8
`define CEO_BADDR_W 13
`define CEO_WADDR_W 11
`define CEO_CFG_REGS 5'h10
`define CEO_CFG_BYTES 13'h0030
`define CEO_CFG_LAST_BYTE 13'h002F
`define CEO_USER_BASE 13'h0030
`define CEO_BYTES_PER_WORD 2'h3
`define CEO_CFG_IDX_RST 5'h00
`define CEO_FLAG_SIGN 1
`define CEO_FLAG_NZ 0
`define CEO_FLAGS_RST 2'h0
`define CEO_RD_CYCLES 6
`define CEO_SET_CYCLES 1
`define CEO_CFG_CYCLES 3
`endif

// file: ceo_pkg.sv
// types for the configuration-write, memory-read and flag-set executor
`default_nettype none
package ceo_pkg;
  typedef enum logic [1:0] {
    CEO_OP_CFG_WRITE = 2'h0,
    CEO_OP_MEM_READ = 2'h1,
    CEO_OP_FLAG_SET = 2'h2,
    CEO_OP_NONE = 2'h3
  } ceo_op_t;
  typedef enum logic [1:0] {
    CEO_ACC_X = 2'h0,
    CEO_ACC_Y = 2'h1,
    CEO_ACC_Z = 2'h2,
    CEO_ACC_R = 2'h3
  } ceo_acc_t;
  typedef enum logic [6:0] {
    CEO_ST_IDLE = 7'h01,
    CEO_ST_CFG = 7'h02,
    CEO_ST_PUSH = 7'h04,
    CEO_ST_REQ = 7'h08,
    CEO_ST_WAIT = 7'h10,
    CEO_ST_CAP = 7'h20,
    CEO_ST_DONE = 7'h40
  } ceo_state_t;
endpackage : ceo_pkg
`default_nettype wire

// file: ceo_exec.sv
// executor for the configuration-write, memory-read and flag-set opcodes
`timescale 1ns/100ps
`default_nettype none
`include "ceo_consts.svh"

// Overview of operation
// - configuration write stores its 24-bit operand as three bytes
// - configuration lives in bytes 0..47 as sixteen 24-bit registers
// - user code starts at byte 48; configuration writes never go past 47
// - memory read loads chosen accumulator from pointer word, sets flags, 6 cycles
// - memory read holds one program counter stack entry, then releases it
// - flag set raises sign when accumulator is negative, else clears it
// - flag set raises non-zero when accumulator is not zero, else clears it
// - flag set leaves accumulator untouched, one byte, one cycle
// - register operand picks accumulator x, y, z or r
module ceo_exec (
  input wire logic clk, // 250 MHz core clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic start, // one-cycle opcode launch, taken when idle
  input wire ceo_pkg::ceo_op_t op, // opcode kind
  input wire ceo_pkg::ceo_acc_t accumulator_select, // register operand
  input wire logic [`CEO_WORD_W-1:0] imm, // 24-bit configuration operand
  input wire logic [`CEO_WORD_W-1:0] acc_x, // accumulator x value
  input wire logic [`CEO_WORD_W-1:0] acc_y, // accumulator y value
  input wire logic [`CEO_WORD_W-1:0] acc_z, // accumulator z value
  input wire logic [`CEO_WORD_W-1:0] acc_r, // accumulator r value
  input wire logic [`CEO_WADDR_W-1:0] ram_ptr, // ram address pointer
  input wire logic [`CEO_WORD_W-1:0] mem_rdata, // read word, one cycle late
  output logic busy, // opcode in progress
  output logic done, // one-cycle completion pulse
  output logic cfg_full, // all sixteen configuration registers written
  output logic mem_we, // byte write strobe
  output logic [`CEO_BADDR_W-1:0] mem_waddr, // byte write address
  output logic [`CEO_BYTE_W-1:0] mem_wdata, // byte write data
  output logic mem_re, // word read strobe
  output logic [`CEO_WADDR_W-1:0] mem_raddr, // word read address
  output logic stack_push, // claim one stack entry
  output logic stack_pop, // release the stack entry
  output logic acc_we, // accumulator write strobe
  output ceo_pkg::ceo_acc_t acc_wsel, // accumulator written
  output logic [`CEO_WORD_W-1:0] acc_wdata, // accumulator write data
  output logic [1:0] sign_and_zero_flags // bit1 sign, bit0 non-zero
);

  // pick one of the four accumulators
  function automatic logic [`CEO_WORD_W-1:0] acc_pick(
    input ceo_pkg::ceo_acc_t sel,
    input logic [`CEO_WORD_W-1:0] x,
    input logic [`CEO_WORD_W-1:0] y,
    input logic [`CEO_WORD_W-1:0] z,
    input logic [`CEO_WORD_W-1:0] r
  );
    unique case (sel)
      ceo_pkg::CEO_ACC_X: acc_pick = x;
      ceo_pkg::CEO_ACC_Y: acc_pick = y;
      ceo_pkg::CEO_ACC_Z: acc_pick = z;
      ceo_pkg::CEO_ACC_R: acc_pick = r;
    endcase
  endfunction : acc_pick

  // sign and non-zero flags of a word
  function automatic logic [1:0] flags_of(input logic [`CEO_WORD_W-1:0] v);
    logic [1:0] f;
    f = `CEO_FLAGS_RST;
    f[`CEO_FLAG_SIGN] = v[`CEO_WORD_W-1];
    f[`CEO_FLAG_NZ] = |v;
    flags_of = f;
  endfunction : flags_of

  ceo_pkg::ceo_state_t state_q, state_d;
  logic [4:0] cfg_idx_q, cfg_idx_d;
  logic [1:0] byte_q, byte_d;
  logic [`CEO_WORD_W-1:0] imm_q, imm_d;
  ceo_pkg::ceo_acc_t sel_q, sel_d;
  logic [`CEO_WADDR_W-1:0] raddr_q, raddr_d;
  logic [`CEO_WORD_W-1:0] rword_q, rword_d;
  logic [1:0] flags_q, flags_d;
  logic done_q, done_d;
  logic we_q, we_d;
  logic [`CEO_BADDR_W-1:0] waddr_q, waddr_d;
  logic [`CEO_BYTE_W-1:0] wdata_q, wdata_d;
  logic [`CEO_WORD_W-1:0] sel_val;
  logic full;

  assign sel_val = acc_pick(accumulator_select, acc_x, acc_y, acc_z, acc_r);
  assign full = (cfg_idx_q == `CEO_CFG_REGS);

  // next-state logic of the executor
  always_comb begin
    state_d = state_q;
    cfg_idx_d = cfg_idx_q;
    byte_d = byte_q;
    imm_d = imm_q;
    sel_d = sel_q;
    raddr_d = raddr_q;
    rword_d = rword_q;
    flags_d = flags_q;
    done_d = 1'b0;
    we_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    unique case (state_q)
      ceo_pkg::CEO_ST_IDLE: begin
        if (start) begin
          unique case (op)
            ceo_pkg::CEO_OP_CFG_WRITE: begin
              if (full) begin
                done_d = 1'b1;
              end else begin
                imm_d = imm;
                byte_d = 2'h0;
                state_d = ceo_pkg::CEO_ST_CFG;
              end
            end
            ceo_pkg::CEO_OP_MEM_READ: begin
              sel_d = accumulator_select;
              raddr_d = ram_ptr;
              state_d = ceo_pkg::CEO_ST_PUSH;
            end
            ceo_pkg::CEO_OP_FLAG_SET: begin
              flags_d = flags_of(sel_val);
              done_d = 1'b1;
            end
            ceo_pkg::CEO_OP_NONE: begin
              done_d = 1'b0;
            end
          endcase
        end
      end
      ceo_pkg::CEO_ST_CFG: begin
        // byte address is register index times three plus byte number
        we_d = 1'b1;
        waddr_d = `CEO_BADDR_W'(cfg_idx_q) * `CEO_BADDR_W'(3)
                  + `CEO_BADDR_W'(byte_q);
        wdata_d = imm_q[`CEO_WORD_W-1-`CEO_BYTE_W*byte_q -: `CEO_BYTE_W];
        if (byte_q == `CEO_BYTES_PER_WORD - 2'h1) begin
          cfg_idx_d = cfg_idx_q + 5'h01;
          done_d = 1'b1;
          state_d = ceo_pkg::CEO_ST_IDLE;
        end else begin
          byte_d = byte_q + 2'h1;
        end
      end
      ceo_pkg::CEO_ST_PUSH: state_d = ceo_pkg::CEO_ST_REQ;
      ceo_pkg::CEO_ST_REQ: state_d = ceo_pkg::CEO_ST_WAIT;
      ceo_pkg::CEO_ST_WAIT: begin
        rword_d = mem_rdata;
        state_d = ceo_pkg::CEO_ST_CAP;
      end
      ceo_pkg::CEO_ST_CAP: begin
        flags_d = flags_of(rword_q);
        state_d = ceo_pkg::CEO_ST_DONE;
      end
      ceo_pkg::CEO_ST_DONE: begin
        done_d = 1'b1;
        state_d = ceo_pkg::CEO_ST_IDLE;
      end
      default: state_d = ceo_pkg::CEO_ST_IDLE;
    endcase
  end

  // executor registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ceo_pkg::CEO_ST_IDLE;
      cfg_idx_q <= `CEO_CFG_IDX_RST;
      byte_q <= 2'h0;
      imm_q <= 24'h000000;
      sel_q <= ceo_pkg::CEO_ACC_X;
      raddr_q <= 11'h000;
      rword_q <= 24'h000000;
      flags_q <= `CEO_FLAGS_RST;
      done_q <= 1'b0;
      we_q <= 1'b0;
      waddr_q <= 13'h0000;
      wdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cfg_idx_q <= cfg_idx_d;
      byte_q <= byte_d;
      imm_q <= imm_d;
      sel_q <= sel_d;
      raddr_q <= raddr_d;
      rword_q <= rword_d;
      flags_q <= flags_d;
      done_q <= done_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  // outputs
  assign busy = (state_q != ceo_pkg::CEO_ST_IDLE);
  assign done = done_q;
  assign cfg_full = full;
  assign mem_we = we_q;
  assign mem_waddr = waddr_q;
  assign mem_wdata = wdata_q;
  assign mem_re = (state_q == ceo_pkg::CEO_ST_REQ);
  assign mem_raddr = raddr_q;
  assign stack_push = (state_q == ceo_pkg::CEO_ST_PUSH);
  assign stack_pop = (state_q == ceo_pkg::CEO_ST_DONE);
  assign acc_we = (state_q == ceo_pkg::CEO_ST_DONE);
  assign acc_wsel = sel_q;
  assign acc_wdata = rword_q;
  assign sign_and_zero_flags = flags_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence rd_launch_s;
    start && op == ceo_pkg::CEO_OP_MEM_READ && !busy;
  endsequence
  sequence rd_body_s;
    stack_push ##1 mem_re ##3 (acc_we && stack_pop);
  endsequence

  read_sequence_a: assert property (rd_launch_s |=> rd_body_s)
    else $error("memory read did not follow its six-cycle pattern");
  read_done_a: assert property (rd_launch_s |-> ##6 done)
    else $error("memory read did not finish in six cycles");
  stack_pairing_a: assert property (stack_push |-> ##4 stack_pop)
    else $error("stack entry not released after push");
  read_flags_a: assert property (acc_we |->
    sign_and_zero_flags == flags_of(acc_wdata))
    else $error("flags do not match loaded word");
  set_sign_a: assert property (start && op == ceo_pkg::CEO_OP_FLAG_SET
    && !busy |=> sign_and_zero_flags[`CEO_FLAG_SIGN]
    == $past(sel_val[`CEO_WORD_W-1]))
    else $error("sign flag wrong after flag set");
  set_nonzero_a: assert property (start && op == ceo_pkg::CEO_OP_FLAG_SET
    && !busy |=> sign_and_zero_flags[`CEO_FLAG_NZ]
    == ($past(sel_val) != 24'h000000))
    else $error("non-zero flag wrong after flag set");
  set_one_cycle_a: assert property (start && op == ceo_pkg::CEO_OP_FLAG_SET
    && !busy |=> done && !busy && !acc_we)
    else $error("flag set not a one-cycle, side-effect-free opcode");
  cfg_area_a: assert property (mem_we |->
    mem_waddr <= `CEO_CFG_LAST_BYTE)
    else $error("configuration write left the configuration area");
  cfg_three_a: assert property (start && op == ceo_pkg::CEO_OP_CFG_WRITE
    && !busy && !cfg_full |=> ##1 mem_we [*3] ##1 !mem_we)
    else $error("configuration write did not emit three bytes");
  cfg_first_a: assert property ($rose(mem_we) |->
    mem_wdata == $past(imm_q[23:16], 1))
    else $error("configuration first byte is not the top byte");
  sel_hold_a: assert property (busy && !$rose(busy) |->
    $stable(acc_wsel))
    else $error("accumulator choice changed during read");

endmodule : ceo_exec
`default_nettype wire

// file: ceo_mem_model.sv
// program and configuration memory model facing the executor
`timescale 1ns/100ps
`default_nettype none
`include "ceo_consts.svh"
module ceo_mem_model (
  input wire logic clk, // core clock
  input wire logic mem_we, // byte write strobe
  input wire logic [`CEO_BADDR_W-1:0] mem_waddr, // byte address
  input wire logic [`CEO_BYTE_W-1:0] mem_wdata, // byte data
  input wire logic mem_re, // word read strobe
  input wire logic [`CEO_WADDR_W-1:0] mem_raddr, // word address
  output logic [`CEO_WORD_W-1:0] mem_rdata // word, one cycle after strobe
);
  // bytes 0..47 are sixteen configuration words, user code above
  logic [`CEO_BYTE_W-1:0] bytes [0:8191];
  logic [`CEO_WORD_W-1:0] words [0:2047]; // preset by the bench
  logic [`CEO_WORD_W-1:0] noise_q = 24'h5A5A5A; // filler between reads
  // configuration bytes land one at a time
  always @(posedge clk) begin
    if (mem_we) bytes[mem_waddr] <= mem_wdata;
  end
  // answer a read next cycle, otherwise the line keeps changing
  always @(posedge clk) begin
    noise_q <= ~noise_q;
    if (mem_re) mem_rdata <= words[mem_raddr];
    else mem_rdata <= noise_q;
  end
endmodule : ceo_mem_model
`default_nettype wire

// file: tb_cpu_eeprom_and_flag_opcodes.sv
// self-checking bench for the opcode executor
`timescale 1ns/100ps
`default_nettype none
`include "ceo_consts.svh"
module tb_cpu_eeprom_and_flag_opcodes;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  ceo_pkg::ceo_op_t op = ceo_pkg::CEO_OP_FLAG_SET;
  ceo_pkg::ceo_acc_t sel = ceo_pkg::CEO_ACC_X;
  logic [23:0] imm = 24'h000000;
  logic [23:0] acc [4] = '{default: 24'h000000};
  logic [10:0] ptr = 11'h000;
  logic busy, done, cfg_full, mem_we, mem_re, stack_push, stack_pop, acc_we;
  logic [12:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [10:0] mem_raddr;
  logic [23:0] mem_rdata, acc_wdata;
  ceo_pkg::ceo_acc_t acc_wsel;
  logic [1:0] flags;
  logic [1:0] fl = 2'h0; // expected flags
  int err_total = 0;
  int compares = 0;
  int seed = 40218;
  int idx = 0; // configuration words written so far
  logic [12:0] wq_a [$];
  logic [7:0] wq_d [$];
  logic [7:0] cfg_img [48]; // expected configuration area

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  ceo_exec uut (.clk(clk), .rst_n(rst_n), .start(start), .op(op),
    .accumulator_select(sel), .imm(imm), .acc_x(acc[0]), .acc_y(acc[1]),
    .acc_z(acc[2]), .acc_r(acc[3]), .ram_ptr(ptr), .mem_rdata(mem_rdata),
    .busy(busy), .done(done), .cfg_full(cfg_full), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .mem_re(mem_re),
    .mem_raddr(mem_raddr), .stack_push(stack_push), .stack_pop(stack_pop),
    .acc_we(acc_we), .acc_wsel(acc_wsel), .acc_wdata(acc_wdata),
    .sign_and_zero_flags(flags));

  ceo_mem_model mem (.clk(clk), .mem_we(mem_we), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .mem_re(mem_re), .mem_raddr(mem_raddr),
    .mem_rdata(mem_rdata));

  // compare one value and count it
  task automatic chk(input string what, input logic [23:0] seen,
      input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // print the verdict and stop
  task automatic wrap_up();
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // launch one opcode and follow it cycle by cycle to its done pulse, for at most 20 cycles
  task automatic run(input ceo_pkg::ceo_op_t o, input logic [23:0] w);
    int n = 1;
    int exp_n = (o == ceo_pkg::CEO_OP_MEM_READ) ? 6 :
      (o == ceo_pkg::CEO_OP_NONE) ? 21 : 1;
    int rd = (o == ceo_pkg::CEO_OP_MEM_READ) ? 1 : 0;
    int ew = 0;
    int wr = 0;
    int accw = 0;
    int pushes = 0;
    int pops = 0;
    logic [23:0] a = acc[sel];
    if (o == ceo_pkg::CEO_OP_CFG_WRITE && idx < 16) begin
      for (int b = 0; b < 3; b++) begin
        wq_a.push_back(13'(idx * 3 + b));
        wq_d.push_back(imm[23 - 8 * b -: 8]);
        cfg_img[idx * 3 + b] = imm[23 - 8 * b -: 8];
      end
      idx++;
      exp_n = 4;
      ew = 3;
    end
    if (o == ceo_pkg::CEO_OP_FLAG_SET) fl = {a[23], a != 24'h0};
    if (rd == 1) fl = {w[23], w != 24'h0};
    op = o;
    start = 1'b1;
    @(posedge clk);
    #1;
    for (n = 1; n <= 20; n++) begin
      if (mem_we === 1'b1) begin
        chk("write address", mem_waddr, wq_a.pop_front());
        chk("write data", mem_wdata, wq_d.pop_front());
        wr++;
      end
      if (mem_re === 1'b1) chk("read address", mem_raddr, ptr);
      if (acc_we === 1'b1) begin
        chk("acc select", acc_wsel, sel);
        chk("acc data", acc_wdata, w);
        accw++;
      end
      pushes += (stack_push === 1'b1) ? 1 : 0;
      pops += (stack_pop === 1'b1) ? 1 : 0;
      chk("stack order", pops > pushes, 1'b0);
      if (done === 1'b1) break;
      // a read keeps start up one more edge: the busy executor ignores it
      start = (n == 1 && rd == 1) ? 1'b1 : 1'b0;
      @(posedge clk);
      #1;
    end
    chk("done cycle", n, exp_n);
    if (n > 20 && o != ceo_pkg::CEO_OP_NONE) wrap_up();
    chk("flags", flags, fl);
    chk("acc writes", accw, rd);
    chk("stack claims", pushes, rd);
    chk("stack releases", pops, rd);
    chk("write count", wr, ew);
    chk("config full", cfg_full, idx == 16);
    chk("busy at done", busy, 1'b0);
  endtask : run

  // reset, then back-to-back opcodes: configuration first, then a mix
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("reset flags", flags, 2'h0);
    chk("reset full", cfg_full, 1'b0);
    for (int i = 0; i < 90; i++) begin
      logic [23:0] w;
      w = (i % 5 == 1) ? 24'h000000 : 24'($random(seed));
      for (int k = 0; k < 4; k++) begin
        acc[k] = (i % 7 == 3) ? 24'h000000 : 24'($random(seed));
      end
      sel = ceo_pkg::ceo_acc_t'(2'($random(seed)));
      imm = 24'($random(seed));
      ptr = 11'($random(seed));
      mem.words[ptr] = w;
      run(ceo_pkg::ceo_op_t'(i < 18 ? 0 : (i * 7 + i / 3) % 4), w);
    end
    // configuration area as stored, first user byte never touched
    for (int j = 0; j < `CEO_CFG_BYTES; j++) begin
      chk("stored byte", mem.bytes[j], cfg_img[j]);
    end
    chk("user area", mem.bytes[`CEO_USER_BASE], 8'hXX);
    wrap_up();
  end
endmodule : tb_cpu_eeprom_and_flag_opcodes
`default_nettype wire
